// File: rtl/owc_pkg.sv
// constants for the overload window comparator block
// ==========================================================================
// Summary of operation
// - channel result asserts while input lies outside selected window
// - thresholds are 8-bit codes, high resets FF, low resets 00
// - reference word: set0 low, set0 high, set1 low, set1 high bytes
// - channel bit 9 picks reference set 0 or set 1
// - channel bit 15 enables the pair; cleared forces output to 0
// - bits 20-16 give minimum pulse width in converter clocks; 0 none
// - bits 1 and 0 show live high and low results, read only
// - bit 3 latches high result, stays until software writes 0
// - bit 2 latches low result, stays until software writes 0
// - bit 5 interrupt flag from latched results, cleared by writing 0
// - bit 8 gates channel interrupt request toward the CPU
// - write with bit 7 set changes only bits 6-0
// - bit 11 routes channel result to PFC emergency
// - PFC emergency is OR of all channels enabled for it
// - bit 10 routes result to motor emergency, gated by source select
// - channels A, B, C drive overload of PWM channels A, B, C
// - channels B and C have identical registers to channel A
package owc_pkg;
   // ========================================================================
   // register map (word index, byte address is four times it)
   localparam logic [3:0] OWC_IDX_REF = 4'h0;
   localparam logic [3:0] OWC_IDX_CHA = 4'h1;
   localparam logic [5:0] OWC_ADDR_REF = 6'h00;
   localparam logic [5:0] OWC_ADDR_CHA = 6'h04;
   localparam logic [5:0] OWC_ADDR_STEP = 6'h04;
   // ========================================================================
   // reference word fields
   localparam int OWC_SET0_LOW_POS = 0;
   localparam int OWC_SET0_HIGH_POS = 8;
   localparam int OWC_SET1_LOW_POS = 16;
   localparam int OWC_SET1_HIGH_POS = 24;
   localparam logic [7:0] OWC_HIGH_RESET = 8'hFF;
   localparam logic [7:0] OWC_LOW_RESET = 8'h00;
   // ========================================================================
   // channel word fields
   localparam int OWC_LIVE_LOW_POS = 0;
   localparam int OWC_LIVE_HIGH_POS = 1;
   localparam int OWC_LATCH_LOW_POS = 2;
   localparam int OWC_LATCH_HIGH_POS = 3;
   localparam int OWC_IRQ_FLAG_POS = 5;
   localparam int OWC_STATUS_ONLY_POS = 7;
   localparam int OWC_IRQ_EN_POS = 8;
   localparam int OWC_REF_SEL_POS = 9;
   localparam int OWC_MOTOR_EMG_POS = 10;
   localparam int OWC_PFC_EMG_POS = 11;
   localparam int OWC_CMP_EN_POS = 15;
   localparam int OWC_FILTER_POS = 16;
   localparam int OWC_FILTER_WIDTH = 5;
   localparam logic [4:0] OWC_FILTER_RESET = 5'h00;
   localparam logic OWC_FLAG_RESET = 1'b0;
endpackage

// File: rtl/owc_tick.sv
// converter clock edge detector, one sys cycle pulse per rising edge
`timescale 1ns/1ns
module owc_tick
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic converterClock,
   output logic tick
);
   logic prevLevel;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         prevLevel <= 1'b0;
         tick <= 1'b0;
      end
      else
      begin
         prevLevel <= converterClock;
         tick <= converterClock & ~prevLevel;
      end
   end
endmodule

// File: rtl/owc_time_filter.sv
// minimum pulse width filter for one comparator result
`timescale 1ns/1ns
module owc_time_filter
#(
   parameter int WIDTH = 5
)
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic enable,
   input wire logic rawResult,
   input wire logic tick,
   input wire logic [WIDTH-1:0] minWidth,
   output logic result
);
   logic [WIDTH-1:0] count;

   if (WIDTH < 1 || WIDTH > 16)
   begin : badWidth
      $error("owc_time_filter: WIDTH out of range");
   end

   // counts converter clock edges seen while the raw result stays high
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         count <= '0;
      else if (!enable || !rawResult)
         count <= '0;
      // stops at the limit, so a lowered limit cannot make it wrap
      else if (tick && count < minWidth)
         count <= count + 1'b1;
   end

   // release is immediate; only the asserting edge is qualified
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         result <= 1'b0;
      else if (!enable)
         result <= 1'b0;
      else if (minWidth == '0)
         result <= rawResult;
      else
         result <= rawResult && (count >= minWidth);
   end
endmodule

// File: rtl/owc_overload_window_comparator.sv
// overload window comparator control, status and protection outputs
`timescale 1ns/1ns
module owc_overload_window_comparator
#(
   parameter int NUM_CH = 3
)
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [5:0] regAddr,
   input wire logic [31:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regReadData,
   input wire logic converterClock,
   input wire logic [NUM_CH-1:0] aboveHighRaw,
   input wire logic [NUM_CH-1:0] belowLowRaw,
   input wire logic emergencySourceSelect,
   output logic [NUM_CH-1:0][7:0] highThreshold,
   output logic [NUM_CH-1:0][7:0] lowThreshold,
   output logic [NUM_CH-1:0] overload,
   output logic motorEmergency,
   output logic pfcEmergency,
   output logic [NUM_CH-1:0] irqRequest
);
   localparam int FW = owc_pkg::OWC_FILTER_WIDTH;

   // the address decode only serves three channel words
   if (NUM_CH < 1 || NUM_CH > 3)
   begin : badNumCh
      $error("owc: NUM_CH must be 1 to 3");
   end

   // =======================================================================
   // reference levels
   logic [7:0] set0LowLevel;
   logic [7:0] set0HighLevel;
   logic [7:0] set1LowLevel;
   logic [7:0] set1HighLevel;
   logic reference_set_select;
   logic refWrite;

   // one decode feeds both the write enables and the read mux
   assign reference_set_select = regAddr == owc_pkg::OWC_ADDR_REF;
   assign refWrite = regWrite && reference_set_select;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         set0LowLevel <= owc_pkg::OWC_LOW_RESET;
         set0HighLevel <= owc_pkg::OWC_HIGH_RESET;
         set1LowLevel <= owc_pkg::OWC_LOW_RESET;
         set1HighLevel <= owc_pkg::OWC_HIGH_RESET;
      end
      else if (refWrite)
      begin
         set0LowLevel <= regWriteData[owc_pkg::OWC_SET0_LOW_POS +: 8];
         set0HighLevel <= regWriteData[owc_pkg::OWC_SET0_HIGH_POS +: 8];
         set1LowLevel <= regWriteData[owc_pkg::OWC_SET1_LOW_POS +: 8];
         set1HighLevel <= regWriteData[owc_pkg::OWC_SET1_HIGH_POS +: 8];
      end
   end

   // =======================================================================
   // converter clock edges
   logic converterTick;

   owc_tick tickGen
   (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .converterClock(converterClock),
      .tick(converterTick)
   );

   // =======================================================================
   // per channel configuration, status and filtering
   logic [NUM_CH-1:0][31:0] chanWord;
   logic [NUM_CH-1:0] chanResult;
   logic [NUM_CH-1:0] chanMotorEn;
   logic [NUM_CH-1:0] chanPfcEn;
   logic [NUM_CH-1:0] chanSel;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++)
      begin : chan
         logic [FW-1:0] outputTimeFilter;
         logic comparatorEnable;
         logic pfcEmergencyEnable;
         logic motorEmergencyEnable;
         logic referenceSetSelect;
         logic irqEnable;
         logic latchedIrqFlag;
         logic latchedHighResult;
         logic latchedLowResult;
         logic liveHighResult;
         logic liveLowResult;
         logic prevHigh;
         logic prevLow;
         logic setHigh;
         logic setLow;
         logic chWrite;
         logic statusOnly;
         logic [7:0] next_highThreshold;
         logic [7:0] next_lowThreshold;

         // every channel shares one layout, one word apart
         assign chanSel[ch] = regAddr == 6'(owc_pkg::OWC_ADDR_CHA
            + 6'(ch) * owc_pkg::OWC_ADDR_STEP);
         assign chWrite = regWrite && chanSel[ch];
         assign statusOnly = regWriteData[owc_pkg::OWC_STATUS_ONLY_POS];

         // configuration is left alone on a status-only write
         always_ff @(posedge clk_sys or negedge resetn)
         begin
            if (!resetn)
            begin
               outputTimeFilter <= owc_pkg::OWC_FILTER_RESET;
               comparatorEnable <= 1'b0;
               pfcEmergencyEnable <= 1'b0;
               motorEmergencyEnable <= 1'b0;
               referenceSetSelect <= 1'b0;
               irqEnable <= 1'b0;
            end
            else if (chWrite && !statusOnly)
            begin
               outputTimeFilter <=
                  regWriteData[owc_pkg::OWC_FILTER_POS +: FW];
               comparatorEnable <= regWriteData[owc_pkg::OWC_CMP_EN_POS];
               pfcEmergencyEnable <=
                  regWriteData[owc_pkg::OWC_PFC_EMG_POS];
               motorEmergencyEnable <=
                  regWriteData[owc_pkg::OWC_MOTOR_EMG_POS];
               referenceSetSelect <= regWriteData[owc_pkg::OWC_REF_SEL_POS];
               irqEnable <= regWriteData[owc_pkg::OWC_IRQ_EN_POS];
            end
         end

         // reference set select picks which pair drives the dacs
         always_comb
         begin
            next_highThreshold = set0HighLevel;
            next_lowThreshold = set0LowLevel;
            if (referenceSetSelect)
            begin
               next_highThreshold = set1HighLevel;
               next_lowThreshold = set1LowLevel;
            end
         end

         // threshold codes toward the comparator pair of this channel
         always_ff @(posedge clk_sys or negedge resetn)
         begin
            if (!resetn)
            begin
               highThreshold[ch] <= owc_pkg::OWC_HIGH_RESET;
               lowThreshold[ch] <= owc_pkg::OWC_LOW_RESET;
            end
            else
            begin
               highThreshold[ch] <= next_highThreshold;
               lowThreshold[ch] <= next_lowThreshold;
            end
         end

         owc_time_filter #(.WIDTH(FW)) highFilter
         (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .enable(comparatorEnable),
            .rawResult(aboveHighRaw[ch]),
            .tick(converterTick),
            .minWidth(outputTimeFilter),
            .result(liveHighResult)
         );

         owc_time_filter #(.WIDTH(FW)) lowFilter
         (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .enable(comparatorEnable),
            .rawResult(belowLowRaw[ch]),
            .tick(converterTick),
            .minWidth(outputTimeFilter),
            .result(liveLowResult)
         );

         // outside the window means above high or below low
         assign chanResult[ch] = liveHighResult | liveLowResult;
         assign chanMotorEn[ch] = motorEmergencyEnable;
         assign chanPfcEn[ch] = pfcEmergencyEnable;

         always_ff @(posedge clk_sys or negedge resetn)
         begin
            if (!resetn)
            begin
               prevHigh <= 1'b0;
               prevLow <= 1'b0;
            end
            else
            begin
               prevHigh <= liveHighResult;
               prevLow <= liveLowResult;
            end
         end

         // a new assertion sets, so a still-high input can be cleared
         assign setHigh = liveHighResult & ~prevHigh;
         assign setLow = liveLowResult & ~prevLow;

         // writing 1 keeps a flag, writing 0 clears it; set beats clear
         always_ff @(posedge clk_sys or negedge resetn)
         begin
            if (!resetn)
               latchedHighResult <= owc_pkg::OWC_FLAG_RESET;
            else if (setHigh)
               latchedHighResult <= 1'b1;
            else if (chWrite)
               latchedHighResult <= latchedHighResult &
                  regWriteData[owc_pkg::OWC_LATCH_HIGH_POS];
         end

         always_ff @(posedge clk_sys or negedge resetn)
         begin
            if (!resetn)
               latchedLowResult <= owc_pkg::OWC_FLAG_RESET;
            else if (setLow)
               latchedLowResult <= 1'b1;
            else if (chWrite)
               latchedLowResult <= latchedLowResult &
                  regWriteData[owc_pkg::OWC_LATCH_LOW_POS];
         end

         always_ff @(posedge clk_sys or negedge resetn)
         begin
            if (!resetn)
               latchedIrqFlag <= owc_pkg::OWC_FLAG_RESET;
            else if (setHigh || setLow)
               latchedIrqFlag <= 1'b1;
            else if (chWrite)
               latchedIrqFlag <= latchedIrqFlag &
                  regWriteData[owc_pkg::OWC_IRQ_FLAG_POS];
         end

         // the request follows the flag, so clearing it drops the line
         always_ff @(posedge clk_sys or negedge resetn)
         begin
            if (!resetn)
               irqRequest[ch] <= 1'b0;
            else
               irqRequest[ch] <= latchedIrqFlag & irqEnable;
         end

         // one register stage keeps the pin straight off a flip-flop
         always_ff @(posedge clk_sys or negedge resetn)
         begin
            if (!resetn)
               overload[ch] <= 1'b0;
            else
               overload[ch] <= chanResult[ch];
         end

         // status-only bit reads back as zero
         always_comb
         begin
            chanWord[ch] = '0;
            chanWord[ch][owc_pkg::OWC_FILTER_POS +: FW] = outputTimeFilter;
            chanWord[ch][owc_pkg::OWC_CMP_EN_POS] = comparatorEnable;
            chanWord[ch][owc_pkg::OWC_PFC_EMG_POS] = pfcEmergencyEnable;
            chanWord[ch][owc_pkg::OWC_MOTOR_EMG_POS] = motorEmergencyEnable;
            chanWord[ch][owc_pkg::OWC_REF_SEL_POS] = referenceSetSelect;
            chanWord[ch][owc_pkg::OWC_IRQ_EN_POS] = irqEnable;
            chanWord[ch][owc_pkg::OWC_IRQ_FLAG_POS] = latchedIrqFlag;
            chanWord[ch][owc_pkg::OWC_LATCH_HIGH_POS] = latchedHighResult;
            chanWord[ch][owc_pkg::OWC_LATCH_LOW_POS] = latchedLowResult;
            chanWord[ch][owc_pkg::OWC_LIVE_HIGH_POS] = liveHighResult;
            chanWord[ch][owc_pkg::OWC_LIVE_LOW_POS] = liveLowResult;
         end
      end
   endgenerate

   // =======================================================================
   // emergency outputs
   logic next_motorEmergency;
   logic next_pfcEmergency;

   // motor path needs both the channel enable and the source select
   always_comb
   begin
      next_motorEmergency = emergencySourceSelect &&
         (|(chanResult & chanMotorEn));
      next_pfcEmergency = |(chanResult & chanPfcEn);
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         motorEmergency <= 1'b0;
         pfcEmergency <= 1'b0;
      end
      else
      begin
         motorEmergency <= next_motorEmergency;
         pfcEmergency <= next_pfcEmergency;
      end
   end

   // =======================================================================
   // register read, unmapped addresses read zero
   logic [31:0] next_readData;

   always_comb
   begin
      next_readData = '0;
      if (reference_set_select)
      begin
         next_readData[owc_pkg::OWC_SET0_LOW_POS +: 8] = set0LowLevel;
         next_readData[owc_pkg::OWC_SET0_HIGH_POS +: 8] = set0HighLevel;
         next_readData[owc_pkg::OWC_SET1_LOW_POS +: 8] = set1LowLevel;
         next_readData[owc_pkg::OWC_SET1_HIGH_POS +: 8] = set1HighLevel;
      end
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (chanSel[i])
            next_readData = chanWord[i];
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         regReadData <= '0;
      else if (regRead)
         regReadData <= next_readData;
      else
         regReadData <= '0;
   end
endmodule

// File: tb/owc_comparator_model.sv
// analog comparator pairs and converter clock facing the block
`timescale 1ns/1ns
module owc_comparator_model
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [2:0][7:0] volt,
   input wire logic [2:0][7:0] highThreshold,
   input wire logic [2:0][7:0] lowThreshold,
   output logic [2:0] aboveHighRaw,
   output logic [2:0] belowLowRaw,
   output logic converterClock
);
   logic [2:0] divCount;
   // ========================================================================
   // comparators settle one clock late, like a real pair behind its dac
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         aboveHighRaw <= 3'h0;
         belowLowRaw <= 3'h0;
      end
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            aboveHighRaw[i] <= volt[i] > highThreshold[i];
            belowLowRaw[i] <= volt[i] < lowThreshold[i];
         end
      end
   end
   // ========================================================================
   // converter clock runs free, eight system clocks a period
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         divCount <= 3'h0;
      else
         divCount <= divCount + 3'h1;
   end
   assign converterClock = divCount[2];
endmodule

// File: tb/owc_props.sv
// port assertions for the overload window comparator
`timescale 1ns/1ns
module owc_checker
#(
   parameter int NUM_CH = 3
)
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [5:0] regAddr,
   input wire logic [31:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regReadData,
   input wire logic converterClock,
   input wire logic [NUM_CH-1:0] aboveHighRaw,
   input wire logic [NUM_CH-1:0] belowLowRaw,
   input wire logic emergencySourceSelect,
   input wire logic [NUM_CH-1:0][7:0] highThreshold,
   input wire logic [NUM_CH-1:0][7:0] lowThreshold,
   input wire logic [NUM_CH-1:0] overload,
   input wire logic motorEmergency,
   input wire logic pfcEmergency,
   input wire logic [NUM_CH-1:0] irqRequest
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   // ========================================================================
   // bus read steps
   sequence s_idle_read;
      !regRead ##1 1'h1;
   endsequence
   sequence s_chan_read;
      regRead && regAddr == owc_pkg::OWC_ADDR_CHA ##1 1'h1;
   endsequence
   // ========================================================================
   // checks
   a_read_idle_zero: assert property (s_idle_read |-> regReadData == 32'h0)
      else $error("read data not zero outside read cycle");
   a_rsv_bits_zero: assert property (s_chan_read |->
      regReadData[31:21] == 11'h0 && regReadData[7] == 1'h0)
      else $error("reserved or write only bits read nonzero");
   a_thr_reset_codes: assert property ($rose(resetn) |->
      highThreshold == {NUM_CH{8'hFF}} && lowThreshold == '0)
      else $error("threshold outputs not at reset codes");
   a_thr_after_write: assert property ($changed(highThreshold) ||
      $changed(lowThreshold) |-> $past(regWrite) || $past(regWrite, 2))
      else $error("threshold changed without a write");
   a_ovl_has_cause: assert property ($rose(overload[0]) |->
      $past(aboveHighRaw[0] || belowLowRaw[0], 2))
      else $error("overload rose without comparator cause");
   a_pfc_from_ovl: assert property (pfcEmergency |-> |overload)
      else $error("pfc emergency without any channel result");
   a_motor_gated: assert property (motorEmergency |->
      $past(emergencySourceSelect) && |overload)
      else $error("motor emergency not gated by source select");
   a_irq_rise_cause: assert property ($rose(irqRequest[0]) |->
      $past(regWrite) || $past(regWrite, 2) ||
      $past(aboveHighRaw[0] || belowLowRaw[0], 3))
      else $error("interrupt request rose without cause");
   a_irq_held: assert property ($fell(irqRequest[0]) |->
      $past(regWrite) || $past(regWrite, 2))
      else $error("interrupt request dropped without a write");
endmodule
bind owc_overload_window_comparator owc_checker #(.NUM_CH(NUM_CH)) uChk
(
   .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
   .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
   .regReadData(regReadData), .converterClock(converterClock),
   .aboveHighRaw(aboveHighRaw), .belowLowRaw(belowLowRaw),
   .emergencySourceSelect(emergencySourceSelect),
   .highThreshold(highThreshold), .lowThreshold(lowThreshold),
   .overload(overload), .motorEmergency(motorEmergency),
   .pfcEmergency(pfcEmergency), .irqRequest(irqRequest)
);

// File: tb/tb_top.sv
// self-checking bench for the overload window comparator
`timescale 1ns/1ns
module tb_top;
   localparam logic [31:0] CFGM = 32'h00008F00;
   logic clk_sys, resetn, regWrite, regRead, converterClock;
   logic emergencySourceSelect, motorEmergency, pfcEmergency;
   logic [5:0] regAddr;
   logic [31:0] regWriteData, regReadData, refw, seed;
   logic [2:0] aboveHighRaw, belowLowRaw, overload, irqRequest;
   logic [2:0][7:0] highThreshold, lowThreshold, volt;
   logic [31:0] cfg[3];
   logic [1:0] res[3];
   logic [2:0] lat[3];
   int badCount = 0;
   int nTests = 0;
   int cyc = 0;
   owc_overload_window_comparator #(.NUM_CH(3)) DUT
   (
      .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
      .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
      .regReadData(regReadData), .converterClock(converterClock),
      .aboveHighRaw(aboveHighRaw), .belowLowRaw(belowLowRaw),
      .emergencySourceSelect(emergencySourceSelect),
      .highThreshold(highThreshold), .lowThreshold(lowThreshold),
      .overload(overload), .motorEmergency(motorEmergency),
      .pfcEmergency(pfcEmergency), .irqRequest(irqRequest)
   );
   owc_comparator_model partner
   (
      .clk_sys(clk_sys), .resetn(resetn), .volt(volt),
      .highThreshold(highThreshold), .lowThreshold(lowThreshold),
      .aboveHighRaw(aboveHighRaw), .belowLowRaw(belowLowRaw),
      .converterClock(converterClock)
   );
   // ========================================================================
   // reference model
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] thr(int i, int h);
      return refw[8 * (2 * int'(cfg[i][9]) + h) +: 8];
   endfunction
   function automatic logic [31:0] word(int i);
      return cfg[i] | {26'h0, lat[i][2], 1'h0, lat[i][1:0], res[i]};
   endfunction
   // latches follow new assertions only, so a clear sticks while out
   task automatic eval(input bit upd);
      logic [1:0] nr;
      for (int i = 0; i < 3; i++)
      begin
         nr[1] = cfg[i][15] && volt[i] > thr(i, 1);
         nr[0] = cfg[i][15] && volt[i] < thr(i, 0);
         if (upd)
            lat[i] = lat[i] | {|(nr & ~res[i]), nr & ~res[i]};
         res[i] = nr;
      end
   endtask
   // ========================================================================
   // bus and compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp)
      begin
         badCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWriteData <= d;
      regWrite <= 1'h1;
      @(posedge clk_sys);
      regWrite <= 1'h0;
   endtask
   task automatic rc(input logic [5:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'h1;
      @(posedge clk_sys);
      regRead <= 1'h0;
      @(negedge clk_sys);
      chk(regReadData, e);
   endtask
   // settle span covers raw to interrupt request latency
   task automatic settle();
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic conclude();
      if (badCount == 0 && nTests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ========================================================================
   // clock and timeout
   initial
   begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cyc = cyc + 1;
      if (cyc == 3000)
      begin
         badCount++;
         conclude();
      end
   end
   // ========================================================================
   // scenarios
   initial
   begin
      logic pf, mo;
      logic [31:0] t;
      seed = 32'h31E0;
      {regWrite, regRead, emergencySourceSelect, resetn} = 4'h0;
      regAddr = 6'h00;
      regWriteData = 32'h0;
      volt = 24'h808080;
      refw = 32'hFF00FF00;
      foreach (cfg[i])
      begin
         cfg[i] = 32'h0;
         lat[i] = 3'h0;
         res[i] = 2'h0;
      end
      repeat (12) @(posedge clk_sys);
      resetn <= 1'h1;
      rc(owc_pkg::OWC_ADDR_REF, 32'hFF00FF00);
      rc(owc_pkg::OWC_ADDR_CHA, 32'h0);
      wr(6'h20, 32'hFFFFFFFF);
      rc(6'h20, 32'h0);
      repeat (8)
      begin
         refw = rnd();
         wr(owc_pkg::OWC_ADDR_REF, refw);
         rc(owc_pkg::OWC_ADDR_REF, refw);
         t = rnd();
         for (int i = 0; i < 3; i++)
         begin
            cfg[i] = rnd() & CFGM;
            wr(6'(4 * i + 4), cfg[i]);
         end
         emergencySourceSelect <= t[31];
         settle();
         for (int i = 0; i < 3; i++)
         begin
            lat[i] = 3'h0;
            wr(6'(4 * i + 4), (rnd() & 32'hFFFFFF00) | 32'h80);
         end
         eval(0);
         t = rnd();
         volt <= t[23:0];
         settle();
         eval(1);
         pf = 1'h0;
         mo = 1'h0;
         for (int i = 0; i < 3; i++)
         begin
            chk(32'(overload[i]), 32'(|res[i]));
            chk(32'(irqRequest[i]), 32'(lat[i][2] & cfg[i][8]));
            chk(32'(highThreshold[i]), 32'(thr(i, 1)));
            chk(32'(lowThreshold[i]), 32'(thr(i, 0)));
            pf = pf | (|res[i] & cfg[i][11]);
            mo = mo | (|res[i] & cfg[i][10]);
            t = (rnd() & 32'hFFFFFF7F) | 32'h80;
            wr(6'(4 * i + 4), t);
            lat[i] = lat[i] & {t[5], t[3:2]};
            rc(6'(4 * i + 4), word(i));
         end
         chk(32'(pfcEmergency), 32'(pf));
         chk(32'(motorEmergency), 32'(mo & emergencySourceSelect));
      end
      refw = 32'hFF00F010;
      wr(owc_pkg::OWC_ADDR_REF, refw);
      wr(owc_pkg::OWC_ADDR_CHA, 32'h00038000);
      volt <= 24'h808080;
      settle();
      @(posedge clk_sys);
      volt[0] <= 8'hFF;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(32'(overload[0]), 32'h0);
      repeat (40) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(32'(overload[0]), 32'h1);
      wr(owc_pkg::OWC_ADDR_CHA, 32'h0);
      settle();
      chk(32'(overload[0]), 32'h0);
      conclude();
   end
endmodule
